// ===== ciop_pin_model.sv
`default_nettype none
module ciop_pin_model
  import ciop_pkg::*;
(
  // Clock
  input wire logic clk,
  // Driver enables from the port logic
  input wire logic [ciop_pkg::NPINS-1:0] pu_very_weak,
  input wire logic [ciop_pkg::NPINS-1:0] pu_weak,
  input wire logic [ciop_pkg::NPINS-1:0] pu_strong,
  input wire logic [ciop_pkg::NPINS-1:0] pd_strong,
  // Outside device forcing pins
  input wire logic [ciop_pkg::NPINS-1:0] ext_en,
  input wire logic [ciop_pkg::NPINS-1:0] ext_val,
  // Resolved pin levels
  output logic [ciop_pkg::NPINS-1:0] pin_lvl
);
  // -----------
  // Pin levels
  // -----------
  logic [NPINS-1:0] flip = '0;
  // A floating pin wanders each cycle, so a stale level never passes
  always @(posedge clk) begin
    flip <= ~flip;
  end
  // Outside drive wins; pull-down beats pull-ups; undriven pins float
  assign pin_lvl = (ext_en & ext_val) | (~ext_en & ~pd_strong &
    (pu_very_weak | pu_weak | pu_strong | flip));
endmodule
`default_nettype wire

// ===== ciop_pkg.sv
`default_nettype none
package ciop_pkg;

  // ------------------------------------------------------------
  // Geometry
  // ------------------------------------------------------------
  localparam int PORTS = 4;
  localparam int PIN_W = 8;
  localparam int NPINS = PORTS * PIN_W;

  // ------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_P1_DATA = 8'h90;
  localparam logic [7:0] OFS_P2_DATA = 8'ha0;
  localparam logic [7:0] OFS_P3_DATA = 8'hb0;
  localparam logic [7:0] OFS_P4_DATA = 8'hc0;
  localparam logic [7:0] OFS_P1_MSA = 8'hc2;
  localparam logic [7:0] OFS_P1_MSB = 8'hc3;
  localparam logic [7:0] OFS_P2_MSA = 8'hc4;
  localparam logic [7:0] OFS_P2_MSB = 8'hc5;
  localparam logic [7:0] OFS_P3_MSA = 8'hc6;
  localparam logic [7:0] OFS_P3_MSB = 8'hc7;
  localparam logic [7:0] OFS_P4_MSA = 8'hbe;
  localparam logic [7:0] OFS_P4_MSB = 8'hbf;

  // ------------------------------------------------------------
  // Reset values and pin masks
  // ------------------------------------------------------------
  localparam logic [7:0] LATCH_RST = 8'hff;
  localparam logic [7:0] MODE_A_INPUT = 8'hff;
  localparam logic [7:0] MODE_B_INPUT = 8'h00;
  localparam logic [7:0] MODE_A_QUASI = 8'h00;
  // Analog inputs sit on port 2 bits 4..7
  localparam logic [NPINS-1:0] ANALOG_MASK = 32'h0000_f000;
  // Wake pins: port 3 bits 2,3,6 and port 4 bits 0,1
  localparam logic [NPINS-1:0] WAKE_MASK = 32'h034c_0000;
  localparam int P2_IDX = 1;
  localparam int P1_LO = 0;

  // ------------------------------------------------------------
  // Strong pull-up burst, in CPU clocks
  // ------------------------------------------------------------
  localparam logic [1:0] STRONG_CYCLES = 2'h2;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_QUASI,
    MODE_PUSH,
    MODE_INPUT,
    MODE_OPEN
  } ciop_mode_type;

  typedef enum logic [1:0] {
    FLD_DATA,
    FLD_MSA,
    FLD_MSB,
    FLD_NONE
  } ciop_field_type;

endpackage
`default_nettype wire

// ===== ciop_port_modes.sv
`default_nettype none
module ciop_port_modes
  import ciop_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // Register port
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic RMW,
  output logic [7:0] RDATA,
  // Configuration and power state
  input wire logic TRISTATE_FUSE,
  input wire logic POWER_DOWN,
  input wire logic [ciop_pkg::PIN_W-1:0] GENERAL_PURPOSE_IRQ_INPUT,
  // Pins, port 1 in bits 7..0 up to port 4 in bits 31..24
  input wire logic [ciop_pkg::NPINS-1:0] PIN_IN,
  output logic [ciop_pkg::NPINS-1:0] PU_VERY_WEAK,
  output logic [ciop_pkg::NPINS-1:0] PU_WEAK,
  output logic [ciop_pkg::NPINS-1:0] PU_STRONG,
  output logic [ciop_pkg::NPINS-1:0] PD_STRONG,
  output logic [ciop_pkg::NPINS-1:0] IBUF_EN
);
  import ciop_pkg::*;

  // ------------------------------------------------------------
  // Decoders
  // ------------------------------------------------------------

  // Two mode bits to a pin mode
  function automatic ciop_mode_type mode_of(input logic a,
                                            input logic b);
    unique case ({a, b})
      2'b00: mode_of = MODE_QUASI;
      2'b01: mode_of = MODE_PUSH;
      2'b10: mode_of = MODE_INPUT;
      2'b11: mode_of = MODE_OPEN;
    endcase
  endfunction

  // Address to field kind
  function automatic ciop_field_type field_of(input logic [7:0] a);
    unique case (a)
      OFS_P1_DATA, OFS_P2_DATA, OFS_P3_DATA, OFS_P4_DATA:
        field_of = FLD_DATA;
      OFS_P1_MSA, OFS_P2_MSA, OFS_P3_MSA, OFS_P4_MSA:
        field_of = FLD_MSA;
      OFS_P1_MSB, OFS_P2_MSB, OFS_P3_MSB, OFS_P4_MSB:
        field_of = FLD_MSB;
      default:
        field_of = FLD_NONE;
    endcase
  endfunction

  // Address to port number
  function automatic logic [1:0] port_of(input logic [7:0] a);
    unique case (a)
      OFS_P1_DATA, OFS_P1_MSA, OFS_P1_MSB: port_of = 2'h0;
      OFS_P2_DATA, OFS_P2_MSA, OFS_P2_MSB: port_of = 2'h1;
      OFS_P3_DATA, OFS_P3_MSA, OFS_P3_MSB: port_of = 2'h2;
      default: port_of = 2'h3;
    endcase
  endfunction

  // ------------------------------------------------------------
  // Reset release
  // ------------------------------------------------------------

  // Release is synchronised so all state leaves reset together
  logic rst_meta_reg;
  logic rst_n_sync;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_meta_reg <= 1'b0;
      rst_n_sync <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_sync <= rst_meta_reg;
    end
  end

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic init;
    logic [PORTS-1:0][PIN_W-1:0] latch;
    logic [PORTS-1:0][PIN_W-1:0] msa;
    logic [PORTS-1:0][PIN_W-1:0] msb;
    logic [NPINS-1:0][1:0] burst;
    logic [7:0] rdata;
    logic [NPINS-1:0] pu_vw;
    logic [NPINS-1:0] pu_w;
    logic [NPINS-1:0] pu_s;
    logic [NPINS-1:0] pd;
    logic [NPINS-1:0] ibuf;
  } ciop_state_type;

  ciop_state_type st_reg;
  ciop_state_type st_next;

  // Flattened views of the per-port registers
  logic [NPINS-1:0] latch_flat;
  logic [NPINS-1:0] latch_new;
  logic [NPINS-1:0] msa_flat;
  logic [NPINS-1:0] msb_flat;
  logic [NPINS-1:0] sensed;
  ciop_field_type fld;
  logic [1:0] prt;

  assign fld = field_of(ADDR);
  assign prt = port_of(ADDR);
  assign latch_flat = st_reg.latch;
  // A disabled input buffer reads as low
  assign sensed = PIN_IN & st_reg.ibuf;

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.init = 1'b1;

    // Reset defaults are loaded on the first edge after release,
    // because the fuse may not be sampled under async reset
    if (!st_reg.init) begin
      for (int p = 0; p < PORTS; p++) begin
        st_next.msb[p] = MODE_B_INPUT;
        if (TRISTATE_FUSE) begin
          st_next.msa[p] = MODE_A_INPUT;
        end else begin
          st_next.msa[p] = MODE_A_QUASI;
        end
      end
      st_next.msa[P2_IDX] = st_next.msa[P2_IDX] |
        ANALOG_MASK[P2_IDX*PIN_W +: PIN_W];
    end else if (WR) begin
      // Register writes, one port and one field at a time
      unique case (fld)
        FLD_DATA: st_next.latch[prt] = WDATA;
        FLD_MSA: st_next.msa[prt] = WDATA;
        FLD_MSB: st_next.msb[prt] = WDATA;
        FLD_NONE: ;
      endcase
    end

    // Register reads; unmapped offsets read as zero
    st_next.rdata = 8'h00;
    if (RD) begin
      unique case (fld)
        FLD_DATA: begin
          if (RMW) begin
            st_next.rdata = st_reg.latch[prt];
          end else begin
            st_next.rdata = sensed[prt*PIN_W +: PIN_W];
          end
        end
        FLD_MSA: st_next.rdata = st_reg.msa[prt];
        FLD_MSB: st_next.rdata = st_reg.msb[prt];
        FLD_NONE: st_next.rdata = 8'h00;
      endcase
    end

    // Input buffers, alive in power-down only where they can wake
    st_next.ibuf = {NPINS{1'b1}};
    if (POWER_DOWN) begin
      st_next.ibuf = WAKE_MASK;
      st_next.ibuf[P1_LO +: PIN_W] = GENERAL_PURPOSE_IRQ_INPUT;
    end

    // Flat views of the updated registers, taken inside this process
    // so that no loop runs through a separate continuous assignment
    latch_new = st_next.latch;
    msa_flat = st_next.msa;
    msb_flat = st_next.msb;

    // Per-pin drivers from the mode and the latch
    for (int i = 0; i < NPINS; i++) begin
      // Strong burst counts down after a latch rise
      if (latch_new[i] && !latch_flat[i]) begin
        st_next.burst[i] = STRONG_CYCLES;
      end else if (st_reg.burst[i] != 2'h0) begin
        st_next.burst[i] = st_reg.burst[i] - 2'h1;
      end else begin
        st_next.burst[i] = 2'h0;
      end
      st_next.pu_vw[i] = 1'b0;
      st_next.pu_w[i] = 1'b0;
      st_next.pu_s[i] = 1'b0;
      st_next.pd[i] = 1'b0;
      unique case (mode_of(msa_flat[i], msb_flat[i]))
        MODE_QUASI: begin
          st_next.pu_vw[i] = latch_new[i];
          // Weak pull-up yields when an outside device pulls low
          st_next.pu_w[i] = latch_new[i] & PIN_IN[i];
          st_next.pu_s[i] = latch_new[i] &
            (st_next.burst[i] != 2'h0);
          st_next.pd[i] = ~latch_new[i];
        end
        MODE_PUSH: begin
          st_next.pu_s[i] = latch_new[i];
          st_next.pd[i] = ~latch_new[i];
        end
        MODE_INPUT: begin
          // All drivers stay off
          st_next.pu_s[i] = 1'b0;
          st_next.pd[i] = 1'b0;
        end
        MODE_OPEN: begin
          st_next.pd[i] = ~latch_new[i];
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------

  // Async reset leaves every pin tristated until defaults load
  always_ff @(posedge CLK or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      st_reg.init <= 1'b0;
      st_reg.latch <= {PORTS{LATCH_RST}};
      st_reg.msa <= {PORTS{MODE_A_INPUT}};
      st_reg.msb <= {PORTS{MODE_B_INPUT}};
      st_reg.burst <= '0;
      st_reg.rdata <= 8'h00;
      st_reg.pu_vw <= '0;
      st_reg.pu_w <= '0;
      st_reg.pu_s <= '0;
      st_reg.pd <= '0;
      st_reg.ibuf <= {NPINS{1'b1}};
    end else begin
      st_reg <= st_next;
    end
  end

  // ------------------------------------------------------------
  // Outputs, straight from flip-flops
  // ------------------------------------------------------------
  assign RDATA = st_reg.rdata;
  assign PU_VERY_WEAK = st_reg.pu_vw;
  assign PU_WEAK = st_reg.pu_w;
  assign PU_STRONG = st_reg.pu_s;
  assign PD_STRONG = st_reg.pd;
  assign IBUF_EN = st_reg.ibuf;

endmodule
`default_nettype wire

// ===== ciop_port_modes_props.sv
`default_nettype none
module ciop_port_modes_props
  import ciop_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // Register port
  input wire logic RD,
  input wire logic [7:0] RDATA,
  // Power state and pins
  input wire logic POWER_DOWN,
  input wire logic [ciop_pkg::PIN_W-1:0] GENERAL_PURPOSE_IRQ_INPUT,
  input wire logic [ciop_pkg::NPINS-1:0] PIN_IN,
  input wire logic [ciop_pkg::NPINS-1:0] PU_VERY_WEAK,
  input wire logic [ciop_pkg::NPINS-1:0] PU_WEAK,
  input wire logic [ciop_pkg::NPINS-1:0] PU_STRONG,
  input wire logic [ciop_pkg::NPINS-1:0] PD_STRONG,
  input wire logic [ciop_pkg::NPINS-1:0] IBUF_EN
);
  // -------
  // Checks
  // -------
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  logic [NPINS-1:0] qs;
  // Strong pull-up seen while the pin is quasi with latch one
  assign qs = PU_STRONG & PU_VERY_WEAK;
  sequence s_burst_on; $rose(qs[0]); endsequence
  sequence s_burst_two; ##1 qs[0] ##1 !qs[0]; endsequence
  property p_no_fight; (PU_STRONG & PD_STRONG) == '0; endproperty
  property p_vw_pd; (PU_VERY_WEAK & PD_STRONG) == '0; endproperty
  property p_weak_vw; (PU_WEAK & ~PU_VERY_WEAK) == '0; endproperty
  property p_weak_pin; (PU_WEAK & ~$past(PIN_IN)) == '0; endproperty
  property p_ibuf_run; !$past(POWER_DOWN) |-> &IBUF_EN; endproperty
  property p_ibuf_pd;
    $past(POWER_DOWN) |->
      IBUF_EN == (WAKE_MASK | 32'($past(GENERAL_PURPOSE_IRQ_INPUT)));
  endproperty
  property p_rd_idle; !$past(RD) |-> RDATA == 8'h00; endproperty
  property p_burst; s_burst_on |-> s_burst_two; endproperty
  property p_burst_max; (qs & $past(qs) & $past(qs, 2)) == '0; endproperty
  a_no_fight: assert property (p_no_fight)
    else $error("strong up and down at once");
  a_vw_pd: assert property (p_vw_pd)
    else $error("very weak up beside pull-down");
  a_weak_vw: assert property (p_weak_vw)
    else $error("weak up without very weak up");
  a_weak_pin: assert property (p_weak_pin)
    else $error("weak up on a low pin");
  a_ibuf_run: assert property (p_ibuf_run)
    else $error("input buffer off while running");
  a_ibuf_pd: assert property (p_ibuf_pd)
    else $error("wrong buffers alive in power-down");
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data without a read");
  a_burst: assert property (p_burst)
    else $error("strong burst not two cycles");
  a_burst_max: assert property (p_burst_max)
    else $error("strong burst too long");
endmodule
bind ciop_port_modes ciop_port_modes_props u_props (.CLK(CLK),
  .RST_N(RST_N), .RD(RD), .RDATA(RDATA), .POWER_DOWN(POWER_DOWN),
  .GENERAL_PURPOSE_IRQ_INPUT(GENERAL_PURPOSE_IRQ_INPUT), .PIN_IN(PIN_IN),
  .PU_VERY_WEAK(PU_VERY_WEAK), .PU_WEAK(PU_WEAK), .PU_STRONG(PU_STRONG),
  .PD_STRONG(PD_STRONG), .IBUF_EN(IBUF_EN));
`default_nettype wire

// ===== test_ciop_port_modes.sv
`default_nettype none
module test_ciop_port_modes;
  timeunit 1ns;
  timeprecision 1ns;
  import ciop_pkg::*;
  // ---------------
  // Bench and tasks
  // ---------------
  logic clk, rst_n = 0, we = 0, re = 0, rmw = 0, fuse = 0, pd = 0;
  logic [7:0] addr = 0, wdata = 0, rdata, general_purpose_irq_input = 0;
  logic [NPINS-1:0] pin_in, vw, wk, st, pdn, ibuf, ext_en = 0, ext_val = 0;
  int fail_count = 0, samples_checked = 0;
  initial begin
    clk = 0;
    forever #20 clk = ~clk;
  end
  ciop_port_modes u_ciop_port_modes (.CLK(clk), .RST_N(rst_n), .ADDR(addr),
    .WDATA(wdata), .WR(we), .RD(re), .RMW(rmw), .RDATA(rdata),
    .TRISTATE_FUSE(fuse), .POWER_DOWN(pd), .GENERAL_PURPOSE_IRQ_INPUT(general_purpose_irq_input),
    .PIN_IN(pin_in), .PU_VERY_WEAK(vw), .PU_WEAK(wk), .PU_STRONG(st),
    .PD_STRONG(pdn), .IBUF_EN(ibuf));
  ciop_pin_model u_ciop_pin_model (.clk(clk), .pu_very_weak(vw),
    .pu_weak(wk), .pu_strong(st), .pd_strong(pdn), .ext_en(ext_en),
    .ext_val(ext_val), .pin_lvl(pin_in));
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wreg(logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rchk(string n, logic [7:0] a, logic m, logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rmw <= m;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    rmw <= 1'b0;
    #1 chk(n, {24'h0, e}, {24'h0, rdata});
  endtask
  task automatic do_reset(logic f);
    @(posedge clk);
    rst_n <= 1'b0;
    fuse <= f;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    tick(4);
  endtask
  task automatic summarize();
    if (fail_count == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Cut a hang short
  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    summarize();
  end
  initial begin
    do_reset(1'b0);
    chk("reset very weak", ~ANALOG_MASK, vw);
    chk("reset weak", ~ANALOG_MASK, wk);
    rchk("p2 mode a", OFS_P2_MSA, 0, 8'hf0);
    rchk("p4 mode b", OFS_P4_MSB, 0, 8'h00);
    rchk("p1 latch", OFS_P1_DATA, 1, LATCH_RST);
    wreg(8'h91, 8'h5a);
    rchk("unmapped", 8'h91, 0, 8'h00);
    wreg(OFS_P1_DATA, 8'h00);
    #1 chk("quasi low", 32'hff, pdn);
    wreg(OFS_P1_DATA, 8'hff);
    #1 chk("burst 1", 32'hff, st);
    tick(1);
    chk("burst 2", 32'hff, st);
    tick(1);
    chk("burst off", '0, st);
    ext_en <= 32'hff;
    ext_val <= 32'h3c;
    tick(2);
    chk("weak held low", ~ANALOG_MASK & 32'hffffff3c, wk);
    chk("very weak kept", ~ANALOG_MASK, vw);
    rchk("pins", OFS_P1_DATA, 0, 8'h3c);
    rchk("latch", OFS_P1_DATA, 1, 8'hff);
    ext_en <= '0;
    // Pin pairs: quasi, push-pull, input, open-drain
    wreg(OFS_P1_MSA, 8'hf0);
    wreg(OFS_P1_MSB, 8'hcc);
    wreg(OFS_P1_DATA, 8'h55);
    tick(3);
    chk("mix strong", 32'h04, st);
    chk("mix down", 32'h8a, pdn);
    chk("mix very weak", ~ANALOG_MASK & 32'hffffff01, vw);
    chk("mix weak", ~ANALOG_MASK & 32'hffffff01, wk);
    general_purpose_irq_input <= 8'h01;
    pd <= 1'b1;
    tick(2);
    chk("sleep buffers", WAKE_MASK | 32'h1, ibuf);
    rchk("sleep read", OFS_P1_DATA, 0, 8'h01);
    pd <= 1'b0;
    tick(2);
    chk("awake buffers", '1, ibuf);
    do_reset(1'b1);
    chk("fuse drivers", '0, vw | pdn | st | wk);
    rchk("fuse mode a", OFS_P3_MSA, 0, 8'hff);
    summarize();
  end
endmodule
`default_nettype wire
